// File: core/rtcaot_core.sv
`timescale 1ns/100ps
// Contract
// - enabled alarms drive pin when square wave off
// - alarm output works on backup supply
// - one alarm, polarity 1: pin equals flag
// - one alarm, polarity 0: pin inverts flag
// - both alarms, polarity 1: pin ORs flags
// - both alarms, polarity 0: pin NANDs flags
// - nothing enabled: pin follows output level bit
// - no general purpose output on backup
// - normal trim applied once per minute
// - sign 1 adds counts, 0 subtracts
// - adjustment is twice the trim value
// - zero trim value means no trimming
// - coarse trim applies 128 times per second
// - trimming continues on backup supply
// - trimming repeats automatically after trim write
// - square wave wins, then alarms, then output
// - flags not software settable; config write clears
// - coarse plus square wave gives 64 Hz
module rtcaot_core
  import rtcaot_pkg::*;
#(
  parameter logic [6:0] BUS_DEV_ADDR = 7'h2a // arbitrary default slave address
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic osc_in,
  input wire logic on_backup_in,
  input wire logic alarm0_match_in,
  input wire logic alarm1_match_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic multi_function_pin_out,
  output logic multi_function_pin_oe_out,
  output logic external_clock_input_enable_out,
  output logic second_tick_out
);
  typedef struct packed {
    rtcaot_bus_e phase; // serial slave phase
    logic [2:0] bitcnt; // bits seen in the current byte
    logic byte_done; // eighth bit has been clocked
    logic [7:0] shreg; // serial shift register
    logic [7:0] ptr; // register pointer
    logic ptr_phase; // next written byte is the pointer
    logic rw; // current transfer is a read
    logic sda_oe; // pulling the data line low
    logic scl_q; // previous settled clock line
    logic sda_q; // previous settled data line
    logic osc_q; // previous settled oscillator
    logic [7:0] ctrl; // clock_output_control
    logic [7:0] trim; // oscillator_trim
    logic [5:0] wk0; // alarm0 mask and weekday bits
    logic [5:0] wk1; // alarm1 mask and weekday bits
    logic pol; // alarm_output_polarity, shared
    logic flag0; // alarm0_match_flag
    logic flag1; // alarm1_match_flag
    logic mfp_oe; // multi-function pin pull-down
  } rtcaot_core_s;

  localparam rtcaot_core_s RTCAOT_CORE_RESET = '{
    phase: RTCAOT_BUS_IDLE, ctrl: RTCAOT_CTRL_RESET, trim: RTCAOT_TRIM_RESET,
    wk0: RTCAOT_WKDAY_RESET[5:0], wk1: RTCAOT_WKDAY_RESET[5:0], default: '0};

  rtcaot_core_s s_r;
  rtcaot_core_s s_nxt;
  logic [3:0] pins_s; // settled scl, sda, osc, backup
  logic scl_s;
  logic sda_s;
  logic osc_s;
  logic backup_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic osc_tick;
  logic [14:0] presc;
  logic trim_busy;
  logic sqw_en;
  logic alm0_en;
  logic alm1_en;
  logic sqw_level;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic clr0;
  logic clr1;
  logic [7:0] rd_data;
  logic pin_level;

  // register read decode, used for every byte sent
  function automatic logic [7:0] reg_read(input logic [7:0] a, input rtcaot_core_s s);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      RTCAOT_CTRL_ADDR: d = s.ctrl;
      RTCAOT_TRIM_ADDR: d = s.trim;
      RTCAOT_ALM0_WKDAY_ADDR: d = {s.pol, s.wk0[5:3], s.flag0, s.wk0[2:0]};
      RTCAOT_ALM1_WKDAY_ADDR: d = {s.pol, s.wk1[5:3], s.flag1, s.wk1[2:0]};
      default: d = 8'h00; // unmapped reads as zero
    endcase
    return d;
  endfunction

  // pins from outside the clock domain
  rtcaot_sync u_sync (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .async_in({scl_in, sda_in, osc_in, on_backup_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign osc_s = pins_s[1];
  assign backup_s = pins_s[0];
  assign scl_rise = scl_s && !s_r.scl_q;
  assign scl_fall = !scl_s && s_r.scl_q;
  assign bus_start = scl_s && s_r.scl_q && !sda_s && s_r.sda_q;
  assign bus_stop = scl_s && s_r.scl_q && sda_s && !s_r.sda_q;
  assign osc_tick = osc_s && !s_r.osc_q;
  assign sqw_en = s_r.ctrl[RTCAOT_CTRL_SQW_EN];
  assign alm0_en = s_r.ctrl[RTCAOT_CTRL_ALM0_EN];
  assign alm1_en = s_r.ctrl[RTCAOT_CTRL_ALM1_EN];
  assign rd_data = reg_read(s_r.ptr, s_r);

  // trimmed prescaler chain
  rtcaot_trim u_trim (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .osc_tick_in(osc_tick),
    .trim_sign_in(s_r.trim[RTCAOT_TRIM_SIGN]),
    .trim_value_in(s_r.trim[6:0]),
    .coarse_in(s_r.ctrl[RTCAOT_CTRL_COARSE]),
    .prescaler_out(presc),
    .second_tick_out(second_tick_out),
    .trim_busy_out(trim_busy)
  );

  // square wave source from the trimmed chain, or the raw oscillator for the 32K code
  always_comb begin
    sqw_level = osc_s;
    if (s_r.ctrl[RTCAOT_CTRL_COARSE]) begin
      sqw_level = presc[RTCAOT_TAP_64HZ]; // trimmed 64 Hz
    end else begin
      unique case (s_r.ctrl[RTCAOT_CTRL_FS_HI:RTCAOT_CTRL_FS_LO])
        RTCAOT_FS_1HZ: sqw_level = presc[RTCAOT_TAP_1HZ];
        RTCAOT_FS_4K: sqw_level = presc[RTCAOT_TAP_4K];
        RTCAOT_FS_8K: sqw_level = presc[RTCAOT_TAP_8K];
        RTCAOT_FS_32K: sqw_level = osc_s; // untrimmed raw clock
      endcase
    end
  end

  // serial slave, register file, flags and pin
  always_comb begin
    s_nxt = s_r;
    wr_en = 1'b0;
    wr_addr = s_r.ptr;
    wr_data = s_r.shreg;
    clr0 = 1'b0;
    clr1 = 1'b0;
    pin_level = 1'b1;
    s_nxt.scl_q = scl_s;
    s_nxt.sda_q = sda_s;
    s_nxt.osc_q = osc_s;
    // count clock rises in every data-carrying phase
    if (scl_rise && (s_r.phase inside {RTCAOT_BUS_ADDR, RTCAOT_BUS_WRITE, RTCAOT_BUS_READ})) begin
      s_nxt.bitcnt = s_r.bitcnt + 3'h1;
      s_nxt.byte_done = (s_r.bitcnt == 3'h7);
      if (s_r.phase != RTCAOT_BUS_READ) begin
        s_nxt.shreg = {s_r.shreg[6:0], sda_s};
      end
    end
    unique case (s_r.phase)
      RTCAOT_BUS_IDLE: begin
        s_nxt.sda_oe = 1'b0;
      end
      RTCAOT_BUS_ADDR: begin
        if (scl_fall && s_r.byte_done) begin
          s_nxt.byte_done = 1'b0;
          if (s_r.shreg[7:1] == BUS_DEV_ADDR) begin
            s_nxt.sda_oe = 1'b1; // acknowledge our address
            s_nxt.rw = s_r.shreg[0];
            s_nxt.ptr_phase = !s_r.shreg[0];
            s_nxt.phase = RTCAOT_BUS_ACK;
          end else begin
            s_nxt.phase = RTCAOT_BUS_IDLE;
          end
        end
      end
      RTCAOT_BUS_ACK: begin
        if (scl_fall) begin
          if (s_r.rw) begin
            s_nxt.shreg = rd_data; // load and present the first bit
            s_nxt.sda_oe = !rd_data[7];
            s_nxt.ptr = s_r.ptr + 8'h01;
            s_nxt.phase = RTCAOT_BUS_READ;
          end else begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.phase = RTCAOT_BUS_WRITE;
          end
        end
      end
      RTCAOT_BUS_WRITE: begin
        if (scl_fall && s_r.byte_done) begin
          s_nxt.byte_done = 1'b0;
          s_nxt.sda_oe = 1'b1;
          s_nxt.phase = RTCAOT_BUS_ACK;
          if (s_r.ptr_phase) begin
            s_nxt.ptr = s_r.shreg; // first byte sets the pointer
            s_nxt.ptr_phase = 1'b0;
          end else begin
            wr_en = 1'b1;
            s_nxt.ptr = s_r.ptr + 8'h01;
          end
        end
      end
      RTCAOT_BUS_READ: begin
        if (scl_fall) begin
          if (s_r.byte_done) begin
            s_nxt.byte_done = 1'b0;
            s_nxt.sda_oe = 1'b0; // let the master acknowledge
            s_nxt.phase = RTCAOT_BUS_RACK;
          end else begin
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            s_nxt.sda_oe = !s_r.shreg[6];
          end
        end
      end
      RTCAOT_BUS_RACK: begin
        if (scl_rise) begin
          s_nxt.phase = sda_s ? RTCAOT_BUS_IDLE : RTCAOT_BUS_ACK; // not acked ends the read
        end
      end
      default: begin
        s_nxt.phase = RTCAOT_BUS_IDLE;
        s_nxt.sda_oe = 1'b0;
      end
    endcase
    // start and stop override any phase
    if (bus_start) begin
      s_nxt.phase = RTCAOT_BUS_ADDR;
      s_nxt.bitcnt = 3'h0;
      s_nxt.byte_done = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end else if (bus_stop) begin
      s_nxt.phase = RTCAOT_BUS_IDLE;
      s_nxt.sda_oe = 1'b0;
    end
    // the bus is not served from the backup supply
    if (backup_s) begin
      s_nxt.phase = RTCAOT_BUS_IDLE;
      s_nxt.sda_oe = 1'b0;
      wr_en = 1'b0;
    end
    // register writes
    if (wr_en) begin
      unique case (wr_addr)
        RTCAOT_CTRL_ADDR: s_nxt.ctrl = wr_data;
        RTCAOT_TRIM_ADDR: s_nxt.trim = wr_data;
        RTCAOT_ALM0_WKDAY_ADDR: begin
          s_nxt.pol = wr_data[RTCAOT_WK_POL];
          s_nxt.wk0 = {wr_data[6:4], wr_data[2:0]};
          clr0 = 1'b1;
        end
        RTCAOT_ALM1_WKDAY_ADDR: begin
          s_nxt.pol = wr_data[RTCAOT_WK_POL];
          s_nxt.wk1 = {wr_data[6:4], wr_data[2:0]};
          clr1 = 1'b1;
        end
        default: ; // unmapped writes are dropped
      endcase
    end
    // flags: only hardware sets, a config write clears, a match wins
    s_nxt.flag0 = alarm0_match_in || (s_r.flag0 && !clr0);
    s_nxt.flag1 = alarm1_match_in || (s_r.flag1 && !clr1);
    // output mode priority
    if (sqw_en) begin
      pin_level = backup_s ? 1'b1 : sqw_level;
    end else if (alm0_en && alm1_en) begin
      // combined alarms, also on backup
      pin_level = s_r.pol ? (s_r.flag0 || s_r.flag1) : !(s_r.flag0 && s_r.flag1);
    end else if (alm0_en || alm1_en) begin
      // single alarm
      pin_level = (alm0_en ? s_r.flag0 : s_r.flag1) ~^ s_r.pol;
    end else begin
      pin_level = backup_s ? 1'b1 : s_r.ctrl[RTCAOT_CTRL_GPO_LEVEL];
    end
    s_nxt.mfp_oe = !pin_level; // pull low for zero, release for one
  end

  // state register
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= RTCAOT_CORE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = s_r.sda_oe;
  assign multi_function_pin_out = 1'b0;
  assign multi_function_pin_oe_out = s_r.mfp_oe;
  assign external_clock_input_enable_out = s_r.ctrl[RTCAOT_CTRL_EXT_CLK];

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_wk0_write;
    wr_en && (wr_addr == RTCAOT_ALM0_WKDAY_ADDR) && !alarm0_match_in;
  endsequence

  sequence s_alarm0_on_backup;
    alarm0_match_in && backup_s && !sqw_en && alm0_en && !alm1_en && !s_r.pol;
  endsequence

  a_single_pol_high:
    assert property ((!sqw_en && alm0_en && !alm1_en && s_r.pol) |=> multi_function_pin_oe_out == !$past(s_r.flag0))
    else $error("single alarm, polarity high, pin does not follow flag");
  a_single_pol_low:
    assert property ((!sqw_en && !alm0_en && alm1_en && !s_r.pol) |=> multi_function_pin_oe_out == $past(s_r.flag1))
    else $error("single alarm, polarity low, pin does not invert flag");
  a_dual_or_flags:
    assert property ((!sqw_en && alm0_en && alm1_en && s_r.pol)
      |=> multi_function_pin_oe_out == !($past(s_r.flag0) || $past(s_r.flag1)))
    else $error("dual alarm OR not on pin");
  a_dual_nand_flags:
    assert property ((!sqw_en && alm0_en && alm1_en && !s_r.pol)
      |=> multi_function_pin_oe_out == ($past(s_r.flag0) && $past(s_r.flag1)))
    else $error("dual alarm NAND not on pin");
  a_gpo_level:
    assert property ((!sqw_en && !alm0_en && !alm1_en && !backup_s)
      |=> multi_function_pin_oe_out == !$past(s_r.ctrl[RTCAOT_CTRL_GPO_LEVEL]))
    else $error("general purpose output level wrong");
  a_gpo_backup_off:
    assert property ((!sqw_en && !alm0_en && !alm1_en && backup_s) |=> !multi_function_pin_oe_out)
    else $error("general purpose output driven on backup");
  a_backup_alarm_pin:
    assert property (s_alarm0_on_backup |-> ##2 multi_function_pin_oe_out)
    else $error("alarm not on pin while on backup");
  a_sqw_priority:
    assert property ((sqw_en && !backup_s) |=> multi_function_pin_oe_out == !$past(sqw_level))
    else $error("square wave does not own the pin");
  a_flag_write_clear:
    assert property (s_wk0_write |=> !s_r.flag0)
    else $error("config write did not clear flag");
  a_flag_no_soft_set:
    assert property ((!s_r.flag0 && !alarm0_match_in) |=> !s_r.flag0)
    else $error("flag set without a match");
  a_zero_trim_idle:
    assert property ((s_r.trim[6:0] == 7'h00 && !trim_busy) |=> !trim_busy)
    else $error("trimming started with zero trim value");
endmodule

// File: core/rtcaot_pkg.sv
package rtcaot_pkg;
  // register addresses on the serial bus
  localparam logic [7:0] RTCAOT_CTRL_ADDR = 8'h07;
  localparam logic [7:0] RTCAOT_TRIM_ADDR = 8'h08;
  localparam logic [7:0] RTCAOT_ALM0_WKDAY_ADDR = 8'h0d;
  localparam logic [7:0] RTCAOT_ALM1_WKDAY_ADDR = 8'h14;
  // reset values
  localparam logic [7:0] RTCAOT_CTRL_RESET = 8'h80;
  localparam logic [7:0] RTCAOT_TRIM_RESET = 8'h00;
  localparam logic [7:0] RTCAOT_WKDAY_RESET = 8'h00;
  // clock_output_control field positions
  localparam int RTCAOT_CTRL_GPO_LEVEL = 7;
  localparam int RTCAOT_CTRL_SQW_EN = 6;
  localparam int RTCAOT_CTRL_ALM1_EN = 5;
  localparam int RTCAOT_CTRL_ALM0_EN = 4;
  localparam int RTCAOT_CTRL_EXT_CLK = 3;
  localparam int RTCAOT_CTRL_COARSE = 2;
  localparam int RTCAOT_CTRL_FS_HI = 1;
  localparam int RTCAOT_CTRL_FS_LO = 0;
  // alarm weekday/config field positions
  localparam int RTCAOT_WK_POL = 7;
  localparam int RTCAOT_WK_FLAG = 3;
  // oscillator_trim field positions
  localparam int RTCAOT_TRIM_SIGN = 7;
  // square wave frequency select codes
  localparam logic [1:0] RTCAOT_FS_1HZ = 2'h0;
  localparam logic [1:0] RTCAOT_FS_4K = 2'h1;
  localparam logic [1:0] RTCAOT_FS_8K = 2'h2;
  localparam logic [1:0] RTCAOT_FS_32K = 2'h3;
  // prescaler taps for each divided square wave rate
  localparam int RTCAOT_TAP_1HZ = 14;
  localparam int RTCAOT_TAP_4K = 2;
  localparam int RTCAOT_TAP_8K = 1;
  localparam int RTCAOT_TAP_64HZ = 8;
  // oscillator timing
  localparam int RTCAOT_OSC_HZ = 32768;
  localparam int RTCAOT_SEC_PER_MIN = 60;
  localparam int RTCAOT_COARSE_HZ = 128;
  localparam logic [14:0] RTCAOT_PRESC_MAX = 15'(RTCAOT_OSC_HZ - 1);
  localparam logic [5:0] RTCAOT_SEC_MAX = 6'(RTCAOT_SEC_PER_MIN - 1);
  localparam logic [14:0] RTCAOT_COARSE_MASK = 15'(RTCAOT_OSC_HZ / RTCAOT_COARSE_HZ - 1);
  // serial bus slave phases, one-hot
  typedef enum logic [5:0] {
    RTCAOT_BUS_IDLE = 6'h01,
    RTCAOT_BUS_ADDR = 6'h02,
    RTCAOT_BUS_ACK = 6'h04,
    RTCAOT_BUS_WRITE = 6'h08,
    RTCAOT_BUS_READ = 6'h10,
    RTCAOT_BUS_RACK = 6'h20
  } rtcaot_bus_e;
endpackage

// File: core/rtcaot_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for the asynchronous pins
module rtcaot_sync
  import rtcaot_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);
  typedef struct packed {
    logic [3:0] first; // metastability catcher, read only by second
    logic [3:0] second; // settled copy
  } rtcaot_sync_s;
  rtcaot_sync_s s_r;
  rtcaot_sync_s s_nxt;

  // shift the pins through two stages
  always_comb begin
    s_nxt = s_r;
    s_nxt.first = async_in;
    s_nxt.second = s_r.first;
  end

  // state register
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '{first: 4'h0, second: 4'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.second;
endmodule

// File: core/rtcaot_trim.sv
`timescale 1ns/100ps
// trimmed prescaler chain: adds or swallows oscillator counts
module rtcaot_trim
  import rtcaot_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic osc_tick_in,
  input wire logic trim_sign_in,
  input wire logic [6:0] trim_value_in,
  input wire logic coarse_in,
  output logic [14:0] prescaler_out,
  output logic second_tick_out,
  output logic trim_busy_out
);
  typedef struct packed {
    logic [14:0] presc; // oscillator count within the second
    logic [5:0] sec; // seconds within the minute
    logic [7:0] pend; // counts still to add or swallow
    logic add; // direction of the pending correction
    logic tick; // second boundary pulse
  } rtcaot_trim_s;
  rtcaot_trim_s s_r;
  rtcaot_trim_s s_nxt;
  logic inc;
  logic wrap;
  logic min_wrap;
  logic trim_event;

  // count, correct and schedule the next correction
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    inc = osc_tick_in;
    // corrections step the chain by one count at a time, so no second is skipped
    if (s_r.pend != 8'h00) begin
      if (!s_r.add && osc_tick_in) begin
        inc = 1'b0; // swallow an oscillator count
        s_nxt.pend = s_r.pend - 8'h01;
      end else if (s_r.add && !osc_tick_in) begin
        inc = 1'b1; // insert an extra count between oscillator edges
        s_nxt.pend = s_r.pend - 8'h01;
      end
    end
    wrap = inc && (s_r.presc == RTCAOT_PRESC_MAX);
    min_wrap = wrap && (s_r.sec == RTCAOT_SEC_MAX);
    if (inc) begin
      s_nxt.presc = s_r.presc + 15'h0001;
    end
    if (wrap) begin
      s_nxt.tick = 1'b1;
      s_nxt.sec = min_wrap ? 6'h00 : s_r.sec + 6'h01;
    end
    // once a minute, or at 128 Hz in coarse mode
    trim_event = coarse_in ? (inc && ((s_r.presc & RTCAOT_COARSE_MASK) == RTCAOT_COARSE_MASK)) : min_wrap;
    // a zero code loads nothing; each step is two counts
    if (trim_event && (s_r.pend == 8'h00) && (trim_value_in != 7'h00)) begin
      s_nxt.pend = {trim_value_in, 1'b0};
      s_nxt.add = trim_sign_in;
    end
  end

  // state register; trimming runs on either supply
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '{presc: 15'h0000, sec: 6'h00, pend: 8'h00, add: 1'b0, tick: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prescaler_out = s_r.presc;
  assign second_tick_out = s_r.tick;
  assign trim_busy_out = (s_r.pend != 8'h00);
endmodule

// File: dv/rtcaot_core_bench.sv
`timescale 1ns/100ps
// self-checking bench for the alarm pin and trim block
module rtcaot_core_bench
  import rtcaot_pkg::*;
;
  logic mclk_in, rstn_in, scl, sda, osc, on_backup, alm0, alm1; // design inputs
  logic sda_oe, mfp_oe, ext_en, nak; // design and host outputs
  logic pin; // pin level with its pull-up
  int failures, cmp_count;
  assign pin = !mfp_oe;
  rtcaot_core #(.BUS_DEV_ADDR(7'h2a)) DUT (.mclk_in(mclk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda),
    .osc_in(osc), .on_backup_in(on_backup), .alarm0_match_in(alm0), .alarm1_match_in(alm1), .sda_out(),
    .sda_oe_out(sda_oe), .multi_function_pin_out(), .multi_function_pin_oe_out(mfp_oe),
    .external_clock_input_enable_out(ext_en), .second_tick_out());
  rtcaot_host #(.DEV_ADDR(7'h2a)) host (.mclk_in(mclk_in), .dev_pull_in(sda_oe), .scl_out(scl), .sda_out(sda),
    .nak_out(nak));
  // 10 MHz clock and a fast oscillator, four clocks a count
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  initial begin
    osc = 1'b0;
    forever #200 osc = ~osc;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // compare tasks: register byte, pin level, duration in cycles
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, m, got, exp);
    end
  endtask
  task automatic chkr(input int got, input int exp, input string m);
    cmp_count++;
    if (got < exp - 6 || got > exp + 6) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask
  // bus access wrappers
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    chk1(nak, 1'b0, "write acked");
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string m);
    logic [7:0] q;
    host.rd(a, q);
    chk8(q, exp, m);
  endtask
  // one-cycle match pulse from an alarm comparator
  task automatic pulse(input int i);
    if (i == 0) alm0 = 1'b1;
    else alm1 = 1'b1;
    hw(1);
    alm0 = 1'b0;
    alm1 = 1'b0;
  endtask
  // expected pin in alarm mode from enables, polarity and flags
  task automatic apin(input logic [1:0] en, input logic pol, input logic [1:0] f);
    logic on;
    hw(3);
    on = (en == 2'b11) ? (pol ? |f : &f) : (en[0] ? f[0] : f[1]);
    chk1(pin, pol ? on : !on, "alarm pin");
  endtask
  // cycles until the pin changes level, bounded
  task automatic till_edge(output int n);
    logic l;
    l = pin;
    n = 0;
    while (pin === l && n < 3000) begin
      hw(1);
      n++;
    end
  endtask
  // reset values, read back and an unmapped place
  task automatic t_regs();
    rchk(RTCAOT_CTRL_ADDR, RTCAOT_CTRL_RESET, "ctrl reset");
    rchk(RTCAOT_TRIM_ADDR, RTCAOT_TRIM_RESET, "trim reset");
    chk1(pin, 1'b1, "gpo high after reset");
    wreg(RTCAOT_TRIM_ADDR, 8'ha5);
    rchk(RTCAOT_TRIM_ADDR, 8'ha5, "trim rw");
    rchk(8'h30, 8'h00, "unmapped");
  endtask
  // general purpose level, and its release on backup
  task automatic t_gpo();
    wreg(RTCAOT_CTRL_ADDR, 8'h08);
    hw(2);
    chk1(pin, 1'b0, "gpo low");
    chk1(ext_en, 1'b1, "ext clock bit");
    on_backup = 1'b1;
    hw(6);
    chk1(pin, 1'b1, "gpo off on backup");
    on_backup = 1'b0;
    hw(6);
  endtask
  // each nonzero enable pair and polarity against the flag combinations
  task automatic t_alarm();
    for (int en = 1; en <= 3; en++) begin
      wreg(RTCAOT_CTRL_ADDR, {2'b00, 2'(en), 4'h0});
      for (int p = 0; p <= 1; p++) begin
        wreg(RTCAOT_ALM0_WKDAY_ADDR, {1'(p), 7'h08}); // flag written as 1 stays clear
        wreg(RTCAOT_ALM1_WKDAY_ADDR, {1'(p), 7'h00});
        apin(2'(en), 1'(p), 2'b00);
        on_backup = !1'(p); // polarity 0 passes runs on backup, so the alarm pin is seen there
        hw(3);
        pulse(0);
        apin(2'(en), 1'(p), 2'b01);
        pulse(1);
        apin(2'(en), 1'(p), 2'b11);
        on_backup = 1'b0;
        hw(6);
        rchk(RTCAOT_ALM0_WKDAY_ADDR, {1'(p), 7'h08}, "flag set by match");
        wreg(RTCAOT_ALM0_WKDAY_ADDR, {1'(p), 7'h00}); // write clears flag
        apin(2'(en), 1'(p), 2'b10);
      end
    end
  endtask
  // trimmed 64 Hz half period: 256 counts, one trim event in each
  task automatic t_trim();
    // cleared first, then sign 1 for a slow clock and 0 for a fast one
    logic [7:0] tv [5] = '{8'h00, 8'h01, 8'h81, 8'h90, 8'h10};
    int ex, n;
    wreg(RTCAOT_CTRL_ADDR, 8'h54); // square wave wins over alarm0
    for (int k = 0; k < 5; k++) begin
      wreg(RTCAOT_TRIM_ADDR, tv[k]);
      // expected count from sign and code, the host formula worked backwards
      ex = tv[k][7] ? (256 - 2 * int'(tv[k][6:0])) * 4 : (256 + 2 * int'(tv[k][6:0])) * 4;
      till_edge(n);
      till_edge(n);
      till_edge(n);
      chkr(n, ex, "64 Hz half period");
    end
    on_backup = 1'b1;
    hw(6);
    till_edge(n);
    chkr(n, 3000, "square wave off on backup");
    on_backup = 1'b0;
  endtask
  // divided and raw square wave rates, exact half periods in clocks
  task automatic t_rates();
    int ex [3] = '{16, 8, 2};
    int n;
    for (int fs = 1; fs <= 3; fs++) begin
      wreg(RTCAOT_CTRL_ADDR, {6'b010000, 2'(fs)});
      hw(200); // let a correction left from coarse mode run out
      till_edge(n);
      till_edge(n);
      chk8(8'(n), 8'(ex[fs - 1]), "square wave rate");
    end
  endtask
  // report counts and verdict, then end the run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog: the sequence needs about 5 ms
  initial begin
    #8000000;
    failures++;
    print_verdict();
  end
  // main sequence
  initial begin
    failures = 0;
    cmp_count = 0;
    rstn_in = 1'b0;
    on_backup = 1'b0;
    alm0 = 1'b0;
    alm1 = 1'b0;
    hw(2);
    rstn_in = 1'b1;
    hw(6);
    t_regs();
    t_gpo();
    t_alarm();
    t_trim();
    t_rates();
    print_verdict();
  end
endmodule

// File: dv/rtcaot_host.sv
`timescale 1ns/100ps
// host side of the two-wire bus: bit-banged master, 1 us half period
module rtcaot_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // must match the slave address
) (
  input wire logic mclk_in,
  input wire logic dev_pull_in,
  output logic scl_out,
  output logic sda_out,
  output logic nak_out
);
  logic pull_r; // host pulls data low
  // open-drain wire with pull-up: low while either side pulls
  assign sda_out = !(pull_r | dev_pull_in);
  // bus idle at time zero
  initial begin
    scl_out = 1'b1;
    pull_r = 1'b0;
    nak_out = 1'b0;
  end
  // wait n edges, then step just past the edge
  task automatic hw(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // one bit: data set while clock low, sampled at the end of the high phase
  task automatic bitx(input logic b, output logic r);
    pull_r = !b;
    hw(8);
    scl_out = 1'b1;
    hw(10);
    r = sda_out;
    scl_out = 1'b0;
    hw(2);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    pull_r = 1'b0;
    hw(4);
    scl_out = 1'b1;
    hw(10);
    pull_r = 1'b1;
    hw(10);
    scl_out = 1'b0;
    hw(2);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    pull_r = 1'b1;
    hw(8);
    scl_out = 1'b1;
    hw(10);
    pull_r = 1'b0;
    hw(10);
  endtask
  // byte msb first, then the ninth bit that the host sends as ab
  task automatic bytex(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ab, r);
  endtask
  // register write: address, pointer, one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic r1, r2, r3;
    start();
    bytex({DEV_ADDR, 1'b0}, 1'b1, q, r1);
    bytex(a, 1'b1, q, r2);
    bytex(d, 1'b1, q, r3);
    stop();
    nak_out = r1 | r2 | r3;
  endtask
  // register read: set pointer, repeated start, one byte then nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic r1, r2, r3, r4;
    start();
    bytex({DEV_ADDR, 1'b0}, 1'b1, q, r1);
    bytex(a, 1'b1, q, r2);
    start();
    bytex({DEV_ADDR, 1'b1}, 1'b1, q, r3);
    bytex(8'hff, 1'b1, d, r4);
    stop();
    nak_out = r1 | r2 | r3;
  endtask
endmodule
